/* nio_pkg.sv */
// Shared constants for the nibble I/O port control block
package nio_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NIO_NUM_PORTS = 7;
  localparam int NIO_NIB_W = 4;
  localparam int NIO_PIN_W = 28;
  localparam int NIO_ADDR_W = 6;
  localparam int NIO_CFG_COUNT = 11;

  // ----------------------------------------------------------------------
  // Port numbering used by the direction and port transfer commands
  // ----------------------------------------------------------------------
  localparam logic [2:0] NIO_PORT_2 = 3'h0;
  localparam logic [2:0] NIO_PORT_3 = 3'h1;
  localparam logic [2:0] NIO_PORT_4 = 3'h2;
  localparam logic [2:0] NIO_PORT_5 = 3'h3;
  localparam logic [2:0] NIO_PORT_6 = 3'h4;
  localparam logic [2:0] NIO_PORT_A = 3'h5;
  localparam logic [2:0] NIO_PORT_B = 3'h6;

  // ----------------------------------------------------------------------
  // Special control register offsets
  // ----------------------------------------------------------------------
  localparam logic [5:0] OFS_PORT4_PULLUP_ENABLE = 6'h03;
  localparam logic [5:0] OFS_PORT4_OUTPUT_TYPE = 6'h04;
  localparam logic [5:0] OFS_PORT6_PULLUP_ENABLE = 6'h05;
  localparam logic [5:0] OFS_PORT6_OUTPUT_TYPE = 6'h06;
  localparam logic [5:0] OFS_PORTAB_PULLUP_ENABLE = 6'h07;
  localparam logic [5:0] OFS_PORTAB_OUTPUT_TYPE = 6'h08;
  localparam logic [5:0] OFS_PORT2_OUTPUT_TYPE = 6'h0d;
  localparam logic [5:0] OFS_PORT3_FUNCTION_SELECT = 6'h0f;
  localparam logic [5:0] OFS_PORT4_FUNCTION_SELECT = 6'h10;
  localparam logic [5:0] OFS_PORT5_FUNCTION_SELECT = 6'h11;
  localparam logic [5:0] OFS_PORT6_FUNCTION_SELECT = 6'h12;

  // Storage slot of each register in the configuration array
  localparam int CFG_P4_PULLUP = 0;
  localparam int CFG_P4_OTYPE = 1;
  localparam int CFG_P6_PULLUP = 2;
  localparam int CFG_P6_OTYPE = 3;
  localparam int CFG_AB_PULLUP = 4;
  localparam int CFG_AB_OTYPE = 5;
  localparam int CFG_P2_OTYPE = 6;
  localparam int CFG_P3_FSEL = 7;
  localparam int CFG_P4_FSEL = 8;
  localparam int CFG_P5_FSEL = 9;
  localparam int CFG_P6_FSEL = 10;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [3:0] DIR_RESET = 4'hf;
  localparam logic [3:0] LATCH_RESET = 4'h0;
  localparam logic [3:0] RDATA_RESET = 4'h0;

  // ----------------------------------------------------------------------
  // Pin capability masks, bit = port*4 + pin, port order 2,3,4,5,6,A,B
  // ----------------------------------------------------------------------
  localparam logic [27:0] PIN_PRESENT = 28'hfff2cf3;
  localparam logic [27:0] SF_CAPABLE = 28'h00f2cf0;
  localparam logic [27:0] SF_OUT_CAPABLE = 28'h00f2000;
  localparam logic [27:0] FALL_CAPABLE = 28'h0000c00;
  localparam logic [27:0] PULLUP_CAPABLE = 28'hfff0c00;
  localparam logic [27:0] OD_CAPABLE = 28'hfff0c03;

endpackage : nio_pkg

/* nio_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and fall detector
`timescale 1ns/1ns

module nio_pin_sync #(
  parameter int WIDTH = 28
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_fall
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] fall_reg;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] level_next;

  // Only stage two and three are compared; stage one may be metastable
  assign agree = ~(stage2_reg ^ stage3_reg);
  assign level_next = (agree & stage3_reg) | (~agree & level_reg);

  // Shift chain and filtered level
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      level_reg <= '0;
      fall_reg <= '0;
    end else if (i_clk_en) begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg <= level_next;
      fall_reg <= level_reg & ~level_next;
    end
  end

  assign o_level = level_reg;
  assign o_fall = fall_reg;

endmodule : nio_pin_sync

/* nio_port_ctrl.sv */
// Port direction, function select, pull-high and open-drain control
`timescale 1ns/1ns

// Functional notes
// - On ports 2 to 6 a direction bit of 0 makes its pin an output, 1 an input.
// - Port read and write commands never alter the ports 2 to 6 directions.
// - Ports A and B turn input on a port read and output on a port write.
// - After reset every pin is an input and every direction nibble is 1111.
// - A port read returns pin levels; a port write loads the output latch.
// - Each port 3 pin can be a normal pin or a special-function input.
// - Port 4 pins 2 and 3 in special mode are falling-edge inputs.
// - Port 5 pin 1 and port 6 pins can be normal or special-function I/O.
// - Port 2, A and B pins have no special-function selection at all.
// - Pull-high for ports 4, 6, A, B; open drain for ports 2, 4, 6, A, B.
// - Pull-high and output-type registers reset to zero.
// - All control registers are 4-bit slots in the 64-entry register area.
// - Port 6 special mode hands its pins to the serial data and clocks.
module nio_port_ctrl import nio_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [3:0] i_reg_wdata,
  output logic [3:0] o_reg_rdata,
  input wire logic i_dir_wr,
  input wire logic [2:0] i_dir_port,
  input wire logic [3:0] i_dir_wdata,
  input wire logic i_io_rd,
  input wire logic i_io_wr,
  input wire logic [2:0] i_io_port,
  input wire logic i_io_use_b,
  input wire logic [3:0] i_acc_a,
  input wire logic [3:0] i_acc_b,
  output logic [3:0] o_io_rdata,
  output logic o_io_rd_to_b,
  output logic o_io_rd_valid,
  input wire logic [27:0] i_pin_in,
  output logic [27:0] o_pin_out,
  output logic [27:0] o_pin_oe,
  output logic [27:0] o_pullup_en,
  input wire logic [27:0] i_sf_out,
  input wire logic [27:0] i_sf_oe,
  output logic [27:0] o_sf_in,
  output logic [27:0] o_sf_fall,
  output logic [27:0] o_sf_sel
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------

  // One-hot port strobe; code 7 selects nothing
  function automatic logic [6:0] port_onehot(input logic [2:0] port);
    logic [6:0] hot;
    hot = 7'h00;
    if (port != 3'h7) begin
      hot[port] = 1'b1;
    end
    return hot;
  endfunction : port_onehot

  // One-hot configuration slot for a register address
  function automatic logic [10:0] cfg_onehot(input logic [5:0] addr);
    logic [10:0] hot;
    hot = 11'h000;
    case (addr)
      OFS_PORT4_PULLUP_ENABLE: hot[CFG_P4_PULLUP] = 1'b1;
      OFS_PORT4_OUTPUT_TYPE: hot[CFG_P4_OTYPE] = 1'b1;
      OFS_PORT6_PULLUP_ENABLE: hot[CFG_P6_PULLUP] = 1'b1;
      OFS_PORT6_OUTPUT_TYPE: hot[CFG_P6_OTYPE] = 1'b1;
      OFS_PORTAB_PULLUP_ENABLE: hot[CFG_AB_PULLUP] = 1'b1;
      OFS_PORTAB_OUTPUT_TYPE: hot[CFG_AB_OTYPE] = 1'b1;
      OFS_PORT2_OUTPUT_TYPE: hot[CFG_P2_OTYPE] = 1'b1;
      OFS_PORT3_FUNCTION_SELECT: hot[CFG_P3_FSEL] = 1'b1;
      OFS_PORT4_FUNCTION_SELECT: hot[CFG_P4_FSEL] = 1'b1;
      OFS_PORT5_FUNCTION_SELECT: hot[CFG_P5_FSEL] = 1'b1;
      OFS_PORT6_FUNCTION_SELECT: hot[CFG_P6_FSEL] = 1'b1;
      default: hot = 11'h000;
    endcase
    return hot;
  endfunction : cfg_onehot

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [3:0] cfg_reg [0:10];
  logic [27:0] port_direction_reg;
  logic [27:0] port_direction_next;
  logic [27:0] output_latch_reg;
  logic [27:0] output_latch_next;
  logic [3:0] io_rdata_reg;
  logic io_rd_to_b_reg;
  logic io_rd_valid_reg;
  logic [3:0] reg_rdata_reg;
  logic [27:0] pin_out_reg;
  logic [27:0] pin_oe_reg;

  // Decoded strobes
  logic [10:0] cfg_hit;
  logic [6:0] dir_hit;
  logic [6:0] io_hit;
  logic [6:0] io_rd_hit;
  logic [6:0] io_wr_hit;
  logic [3:0] acc_sel;
  logic [3:0] cfg_rvalue;
  logic [3:0] io_rd_nibble;
  logic [27:0] pin_level;
  logic [27:0] pin_fall;

  // Per-pin views of the configuration
  logic [27:0] pullup_vec;
  logic [27:0] od_vec;
  logic [27:0] sf_sel;
  logic [27:0] drive_val;
  logic [27:0] drive_en;
  logic [27:0] pin_out_next;
  logic [27:0] pin_oe_next;

  assign cfg_hit = cfg_onehot(i_reg_addr);
  assign dir_hit = port_onehot(i_dir_port) & {7{i_dir_wr}};
  assign io_hit = port_onehot(i_io_port);
  assign io_rd_hit = io_hit & {7{i_io_rd}};
  assign io_wr_hit = io_hit & {7{i_io_wr}};
  assign acc_sel = i_io_use_b ? i_acc_b : i_acc_a;

  // ----------------------------------------------------------------------
  // Pin input synchronisation
  // ----------------------------------------------------------------------
  nio_pin_sync #(
    .WIDTH(NIO_PIN_W)
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_async(i_pin_in),
    .o_level(pin_level),
    .o_fall(pin_fall)
  );

  // ----------------------------------------------------------------------
  // Special control registers
  // ----------------------------------------------------------------------

  // Write port of the register slots; unmapped addresses are ignored
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NIO_CFG_COUNT; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
    end else if (i_clk_en && i_reg_wr) begin
      for (int i = 0; i < NIO_CFG_COUNT; i++) begin
        if (cfg_hit[i]) begin
          cfg_reg[i] <= i_reg_wdata;
        end
      end
    end
  end

  // Read mux; unmapped locations read as zero
  always_comb begin
    cfg_rvalue = 4'h0;
    for (int i = 0; i < NIO_CFG_COUNT; i++) begin
      if (cfg_hit[i]) begin
        cfg_rvalue = cfg_reg[i];
      end
    end
  end

  // Read data is held until the next read
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reg_rdata_reg <= RDATA_RESET;
    end else if (i_clk_en && i_reg_rd) begin
      reg_rdata_reg <= cfg_rvalue;
    end
  end

  // ----------------------------------------------------------------------
  // Per-pin configuration vectors
  // ----------------------------------------------------------------------

  // Port A and B share one pull-high and one type nibble, bit n on pin n
  assign pullup_vec = {cfg_reg[CFG_AB_PULLUP], cfg_reg[CFG_AB_PULLUP],
                       cfg_reg[CFG_P6_PULLUP], 4'h0,
                       cfg_reg[CFG_P4_PULLUP], 8'h00};
  assign od_vec = ({cfg_reg[CFG_AB_OTYPE], cfg_reg[CFG_AB_OTYPE],
                    cfg_reg[CFG_P6_OTYPE], 4'h0, cfg_reg[CFG_P4_OTYPE],
                    4'h0, cfg_reg[CFG_P2_OTYPE]}) & OD_CAPABLE;
  // Masking keeps ports 2, A and B on normal I/O whatever is written
  assign sf_sel = ({8'h00, cfg_reg[CFG_P6_FSEL], cfg_reg[CFG_P5_FSEL],
                    cfg_reg[CFG_P4_FSEL], cfg_reg[CFG_P3_FSEL], 4'h0})
                  & SF_CAPABLE;
  assign o_pullup_en = pullup_vec & PULLUP_CAPABLE;

  // ----------------------------------------------------------------------
  // Direction and output latch next values
  // ----------------------------------------------------------------------
  generate
    for (genvar p = 0; p < NIO_NUM_PORTS; p++) begin : g_port
      if (p >= NIO_PORT_A) begin : g_instr_dir
        // Direction follows the last transfer command only
        assign port_direction_next[p*4 +: 4] =
          io_wr_hit[p] ? 4'h0 :
          io_rd_hit[p] ? 4'hf :
          port_direction_reg[p*4 +: 4];
      end else begin : g_reg_dir
        // Transfer commands are not looked at here
        assign port_direction_next[p*4 +: 4] =
          dir_hit[p] ? i_dir_wdata : port_direction_reg[p*4 +: 4];
      end
      assign output_latch_next[p*4 +: 4] =
        io_wr_hit[p] ? acc_sel : output_latch_reg[p*4 +: 4];
    end
  endgenerate

  // Direction and latch registers
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port_direction_reg <= {NIO_NUM_PORTS{DIR_RESET}};
      output_latch_reg <= {NIO_NUM_PORTS{LATCH_RESET}};
    end else if (i_clk_en) begin
      port_direction_reg <= port_direction_next;
      output_latch_reg <= output_latch_next;
    end
  end

  // ----------------------------------------------------------------------
  // Port read path
  // ----------------------------------------------------------------------

  // Pin levels, not the latch, are returned; absent pins read zero
  assign io_rd_nibble = (i_io_port == 3'h7) ? 4'h0 :
    pin_level[{i_io_port, 2'b00} +: 4] &
    PIN_PRESENT[{i_io_port, 2'b00} +: 4];

  // Read result with its destination accumulator
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      io_rdata_reg <= RDATA_RESET;
      io_rd_to_b_reg <= 1'b0;
      io_rd_valid_reg <= 1'b0;
    end else if (i_clk_en) begin
      io_rd_valid_reg <= i_io_rd;
      if (i_io_rd) begin
        io_rdata_reg <= io_rd_nibble;
        io_rd_to_b_reg <= i_io_use_b;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------

  // Special functions take the pin; port 3 and 4 special pins never drive
  assign drive_val = (sf_sel & i_sf_out) | (~sf_sel & output_latch_reg);
  assign drive_en = (sf_sel & i_sf_oe & SF_OUT_CAPABLE)
                  | (~sf_sel & ~port_direction_reg);
  // Open drain only sinks: a high is released instead of driven
  assign pin_oe_next = drive_en & PIN_PRESENT & ~(od_vec & drive_val);
  assign pin_out_next = drive_val & ~od_vec & PIN_PRESENT;

  // Registered pin outputs avoid glitches on the board
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
    end else if (i_clk_en) begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  // ----------------------------------------------------------------------
  // Special-function inputs
  // ----------------------------------------------------------------------
  assign o_sf_in = pin_level & sf_sel;
  assign o_sf_fall = pin_fall & sf_sel & FALL_CAPABLE;
  assign o_sf_sel = sf_sel;

  assign o_reg_rdata = reg_rdata_reg;
  assign o_io_rdata = io_rdata_reg;
  assign o_io_rd_to_b = io_rd_to_b_reg;
  assign o_io_rd_valid = io_rd_valid_reg;
  assign o_pin_out = pin_out_reg;
  assign o_pin_oe = pin_oe_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // Reset seen at the edge before; state is unknown until the first edge
  logic rst_held_reg;
  always_ff @(posedge i_sys_clk) begin
    rst_held_reg <= !i_reset_n;
  end

  chk_dir_reg_write: assert property (
    i_clk_en && i_dir_wr && i_dir_port == NIO_PORT_3
    |=> port_direction_reg[7:4] == $past(i_dir_wdata)
        ##1 !$past(i_clk_en) || pin_oe_reg[4] || $past(port_direction_reg[4])
            || $past(sf_sel[4]))
    else $error("port 3 direction write not applied");
  chk_io_keeps_dir: assert property (
    i_clk_en && (i_io_rd || i_io_wr) && !i_dir_wr && i_io_port < NIO_PORT_A
    |=> $stable(port_direction_reg))
    else $error("port transfer changed a direction register");
  chk_ab_read_input: assert property (
    i_clk_en && i_io_rd && !i_io_wr && i_io_port == NIO_PORT_A
    |=> port_direction_reg[23:20] == 4'hf)
    else $error("port A read did not select input");
  chk_ab_write_output: assert property (
    i_clk_en && i_io_wr && i_io_port == NIO_PORT_B
    |=> port_direction_reg[27:24] == 4'h0)
    else $error("port B write did not select output");
  chk_reset_inputs: assert property (
    @(posedge i_sys_clk) disable iff (1'b0) !i_reset_n && rst_held_reg
    |-> port_direction_reg == 28'hfffffff && o_pin_oe == 28'h0)
    else $error("pins not all inputs during reset");
  chk_read_levels: assert property (
    i_clk_en && i_io_rd && i_io_port == NIO_PORT_6
    |=> o_io_rd_valid && o_io_rdata == $past(pin_level[19:16]))
    else $error("port read returned wrong levels");
  chk_write_latch: assert property (
    i_clk_en && i_io_wr && i_io_use_b && i_io_port == NIO_PORT_5
    |=> output_latch_reg[15:12] == $past(i_acc_b))
    else $error("port write did not load latch");
  chk_p3_input_only: assert property (
    i_clk_en |=> (o_pin_oe[7:4] & $past(sf_sel[7:4])) == 4'h0)
    else $error("special port 3 pin is driving");
  chk_p4_fall_edge: assert property (
    o_sf_fall[10] && $past(i_clk_en)
    |-> !pin_level[10] && $past(pin_level[10]))
    else $error("port 4 edge event without a falling edge");
  chk_no_sf_normal: assert property (
    sf_sel[27:20] == 8'h00 && sf_sel[3:0] == 4'h0)
    else $error("normal-only pin has a special function");
  chk_od_no_high: assert property (
    $past(i_clk_en) |-> (o_pin_oe & o_pin_out & $past(od_vec)) == 28'h0)
    else $error("open-drain pin driven high");
  chk_cfg_reset: assert property (
    @(posedge i_sys_clk) disable iff (1'b0) !i_reset_n && rst_held_reg
    |-> cfg_reg[CFG_P4_PULLUP] == 4'h0 && cfg_reg[CFG_AB_OTYPE] == 4'h0)
    else $error("configuration not cleared by reset");
  chk_reg_readback: assert property (
    i_clk_en && i_reg_wr && i_reg_addr == OFS_PORT6_FUNCTION_SELECT
    ##1 i_clk_en && i_reg_rd && !i_reg_wr
        && i_reg_addr == OFS_PORT6_FUNCTION_SELECT
    |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("register read back differs from write");
  chk_p6_serial: assert property (
    i_clk_en && sf_sel[16] && i_sf_oe[16] && !od_vec[16]
    |=> o_pin_oe[16] && o_pin_out[16] == $past(i_sf_out[16]))
    else $error("port 6 special pin not driven by serial");

  cov_ab_turnaround: cover property (
    i_clk_en && i_io_wr && i_io_port == NIO_PORT_A
    ##[1:4] i_clk_en && i_io_rd && i_io_port == NIO_PORT_A);
  cov_p4_fall: cover property (o_sf_fall[11]);
  cov_od_release: cover property (od_vec[0] && !o_pin_oe[0]
                                  && !port_direction_reg[0]);
  cov_serial_pins: cover property (sf_sel[19:16] == 4'hf && o_pin_oe[16]);

endmodule : nio_port_ctrl

/* nio_pin_model.sv */
// Behavioural model of the circuitry wired to the port pins
`timescale 1ns/1ns

module nio_pin_model (
  input wire logic i_sys_clk,
  input wire logic [27:0] i_pin_out,
  input wire logic [27:0] i_pin_oe,
  input wire logic [27:0] i_pullup_en,
  input wire logic [27:0] i_ext_en,
  input wire logic [27:0] i_ext_val,
  output logic [27:0] o_pin
);
  logic [27:0] last_reg;
  // Device drive wins, then outside drive, then pull-high; a floating pin
  // toggles so that a stale level is never taken for a real one
  assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext_val)
    | (~i_pin_oe & ~i_ext_en & (i_pullup_en | ~last_reg));
  always_ff @(posedge i_sys_clk) begin
    last_reg <= o_pin;
  end
endmodule : nio_pin_model

/* nibble_io_port_control_test.sv */
// Self-checking testbench for the nibble I/O port control block
`timescale 1ns/1ns

module nibble_io_port_control_test;
  import nio_pkg::*;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, dir_wr = 0;
  logic io_rd = 0, io_wr = 0, use_b = 0, clk_en = 1;
  logic [5:0] addr = 6'h00;
  logic [3:0] wdata = 4'h0, dir_d = 4'h0, acc_a = 4'h0, acc_b = 4'h0;
  logic [3:0] rdata, io_rdata;
  logic [2:0] dir_p = 3'h0, io_p = 3'h0;
  logic to_b, rd_valid;
  logic [27:0] pin, pout, poe, pull, sf_in, sf_fall, sf_sel;
  logic [27:0] sf_out = 28'h0, sf_oe = 28'h0;
  logic [27:0] ext_en = 28'hfffffff, ext_val = 28'hfffffff;
  logic [27:0] e;
  logic [5:0] ofs [11] = '{OFS_PORT4_PULLUP_ENABLE, OFS_PORT4_OUTPUT_TYPE,
    OFS_PORT6_PULLUP_ENABLE, OFS_PORT6_OUTPUT_TYPE, OFS_PORTAB_PULLUP_ENABLE,
    OFS_PORTAB_OUTPUT_TYPE, OFS_PORT2_OUTPUT_TYPE, OFS_PORT3_FUNCTION_SELECT,
    OFS_PORT4_FUNCTION_SELECT, OFS_PORT5_FUNCTION_SELECT,
    OFS_PORT6_FUNCTION_SELECT};
  int fails = 0, n_tests = 0, k;

  // ------------------------------------------------------------------
  // Clock, design and pin model
  // ------------------------------------------------------------------
  always #5 clk = ~clk;
  nio_port_ctrl dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(clk_en),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_dir_wr(dir_wr),
    .i_dir_port(dir_p), .i_dir_wdata(dir_d), .i_io_rd(io_rd),
    .i_io_wr(io_wr), .i_io_port(io_p), .i_io_use_b(use_b), .i_acc_a(acc_a),
    .i_acc_b(acc_b), .o_io_rdata(io_rdata), .o_io_rd_to_b(to_b),
    .o_io_rd_valid(rd_valid), .i_pin_in(pin), .o_pin_out(pout),
    .o_pin_oe(poe), .o_pullup_en(pull), .i_sf_out(sf_out), .i_sf_oe(sf_oe),
    .o_sf_in(sf_in), .o_sf_fall(sf_fall), .o_sf_sel(sf_sel));
  nio_pin_model pins (.i_sys_clk(clk), .i_pin_out(pout), .i_pin_oe(poe),
    .i_pullup_en(pull), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin));

  // ------------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  // Each command is held for exactly one clock edge
  task automatic reg_op(input logic w, input logic [5:0] a,
                        input logic [3:0] d);
    @(posedge clk);
    reg_wr <= w; reg_rd <= ~w; addr <= a; wdata <= d;
    @(posedge clk);
    reg_wr <= 0; reg_rd <= 0;
    #1;
  endtask : reg_op
  task automatic io_op(input logic r, input logic [2:0] p, input logic b);
    @(posedge clk);
    io_rd <= r; io_wr <= ~r; io_p <= p; use_b <= b;
    @(posedge clk);
    io_rd <= 0; io_wr <= 0;
    #1;
  endtask : io_op
  task automatic set_dir(input logic [2:0] p, input logic [3:0] d);
    @(posedge clk);
    dir_wr <= 1; dir_p <= p; dir_d <= d;
    @(posedge clk);
    dir_wr <= 0;
  endtask : set_dir
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 0;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    idle(1);
    check(poe, 28'h0);
    check(pull | sf_sel, 28'h0);
    for (int i = 0; i < 11; i++) begin
      reg_op(0, ofs[i], 4'h0);
      check(28'(rdata), 28'h0);
    end
  endtask : do_reset
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    do_reset();
    $display("reset values done");
    // Distinct value per register; unmapped slots must stay empty
    for (int i = 0; i < 11; i++) reg_op(1, ofs[i], 4'(i + 1));
    reg_op(1, 6'h0e, 4'hf);
    reg_op(0, 6'h0e, 4'h0);
    check(28'(rdata), 28'h0);
    for (int i = 0; i < 11; i++) begin
      reg_op(0, ofs[i], 4'h0);
      check(28'(rdata), 28'(i + 1));
    end
    e = {8'h0, 4'hb, 4'ha, 4'h9, 4'h8, 4'h0} & SF_CAPABLE;
    check(sf_sel, e);
    e = {4'h5, 4'h5, 4'h3, 4'h0, 4'h1, 8'h0} & PULLUP_CAPABLE;
    check(pull, e);
    $display("register map done");
    do_reset();
    // Port 2 output, then a read must not touch its direction
    acc_a <= 4'h2;
    io_op(0, NIO_PORT_2, 0);
    idle(2);
    check(28'(poe[1:0]), 28'h0);
    set_dir(NIO_PORT_2, 4'h0);
    set_dir(NIO_PORT_3, 4'h5);
    set_dir(NIO_PORT_A, 4'h0);
    idle(3);
    check(28'(poe[1:0]), 28'h3);
    check(28'(poe[7:4]), 28'ha);
    check(28'(poe[23:20]), 28'h0);
    check(28'(pout[1:0]), 28'h2);
    idle(4);
    io_op(1, NIO_PORT_2, 1);
    check(28'({to_b, rd_valid}), 28'h3);
    check(28'(io_rdata[1:0]), 28'h2);
    idle(2);
    check(28'(poe[1:0]), 28'h3);
    reg_op(1, OFS_PORT2_OUTPUT_TYPE, 4'h3);
    idle(2);
    check(28'(poe[1:0]), 28'h1);
    $display("port 2 done");
    // Ports A and B follow the transfer commands only
    for (k = 0; k < 2; k++) begin
      acc_b <= 4'h5;
      io_op(0, 3'(NIO_PORT_A + k), 1);
      idle(2);
      check(28'(poe[20 + 4 * k +: 4]), 28'hf);
      check(28'(pout[20 + 4 * k +: 4]), 28'h5);
      ext_val[20 + 4 * k +: 4] <= 4'ha;
      idle(4);
      io_op(1, 3'(NIO_PORT_A + k), 0);
      check(28'({to_b, io_rdata}), 28'h5);
      idle(2);
      check(28'(poe[20 + 4 * k +: 4]), 28'h0);
      idle(4);
      io_op(1, 3'(NIO_PORT_A + k), 1);
      check(28'({to_b, io_rdata}), 28'h1a);
    end
    $display("ports A and B done");
    // Clock enable low: a port B write must not be taken
    @(posedge clk);
    clk_en <= 0;
    io_op(0, NIO_PORT_B, 1);
    idle(2);
    check(28'(poe[27:24]), 28'h0);
    @(posedge clk);
    clk_en <= 1;
    idle(2);
    check(28'(poe[27:24]), 28'h0);
    $display("clock enable done");
    // Port 5 pin 1 as a plain output loaded from accumulator B
    acc_b <= 4'h2;
    io_op(0, NIO_PORT_5, 1);
    set_dir(NIO_PORT_5, 4'h0);
    idle(3);
    check(28'({poe[13], pout[13]}), 28'h3);
    $display("port 5 done");
    // Port 4 special inputs react to a falling level once
    reg_op(1, OFS_PORT4_FUNCTION_SELECT, 4'hc);
    idle(6);
    ext_val[10] <= 1'b0;
    k = 0;
    repeat (10) begin
      idle(1);
      if (sf_fall[10] === 1'b1) k++;
    end
    check(28'(k), 28'h1);
    check(28'(sf_in[11:10]), 28'h2);
    check(28'(sf_fall[11]), 28'h0);
    $display("falling edge done");
    // Port 6 special mode hands the pins to the serial logic
    sf_oe[19:16] <= 4'h5;
    sf_out[19:16] <= 4'h3;
    // Write then read back on the very next edge
    @(posedge clk);
    reg_wr <= 1;
    addr <= OFS_PORT6_FUNCTION_SELECT;
    wdata <= 4'hf;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1;
    check(28'(rdata), 28'hf);
    idle(3);
    check(28'(poe[19:16]), 28'h5);
    check(28'(pout[19:16]), 28'h3);
    $display("port 6 special done");
    give_verdict();
  end
endmodule : nibble_io_port_control_test
